// *** rtl/abs_pkg.sv ***
// package for the data processing datapath: opcodes, shift types, field positions, cycle counts
// assumes a 32-bit core datapath with one core clock
package abs_pkg;

    typedef enum logic [3:0] {
        ABS_OP_AND = 4'h0, ABS_OP_XOR = 4'h1, ABS_OP_SUB = 4'h2, ABS_OP_RSB = 4'h3,
        ABS_OP_ADD = 4'h4, ABS_OP_ADC = 4'h5, ABS_OP_SWC = 4'h6, ABS_OP_RSWC = 4'h7,
        ABS_OP_TAND = 4'h8, ABS_OP_TXOR = 4'h9, ABS_OP_TSUB = 4'ha, ABS_OP_TADD = 4'hb,
        ABS_OP_OR = 4'hc, ABS_OP_MOV = 4'hd, ABS_OP_CLR = 4'he, ABS_OP_INV = 4'hf
    } abs_op_t;

    typedef enum logic [1:0] {
        ABS_SH_LL = 2'h0, ABS_SH_LR = 2'h1, ABS_SH_AR = 2'h2, ABS_SH_RR = 2'h3
    } abs_shift_t;

    // instruction field positions
    localparam int ABS_IMM8_LSB = 0;
    localparam int ABS_ROT_LSB = 8;
    localparam int ABS_SRC_LSB = 0;
    localparam int ABS_REGSH_BIT = 4;
    localparam int ABS_BIT7 = 7;
    localparam int ABS_STYPE_LSB = 5;
    localparam int ABS_SHAMT_LSB = 7;
    localparam int ABS_AMT_LSB = 8;
    localparam int ABS_RD_LSB = 12;
    localparam int ABS_OPA_LSB = 16;
    localparam int ABS_SBIT = 20;
    localparam int ABS_OP_LSB = 21;
    localparam int ABS_IBIT = 25;

    localparam logic [3:0] ABS_PC_INDEX = 4'hf;
    localparam logic [31:0] ABS_PC_AHEAD_IMM = 32'h0000_0008;
    localparam logic [31:0] ABS_PC_AHEAD_REG = 32'h0000_000c;
    localparam logic [7:0] ABS_SH32 = 8'h20;
    localparam logic [4:0] ABS_USER_MODE = 5'h10;

    // cycle counts: plain, internal extra, pc write (2s+1n)
    localparam logic [2:0] ABS_CYC_PLAIN = 3'h1;
    localparam logic [2:0] ABS_CYC_INT = 3'h1;
    localparam logic [2:0] ABS_CYC_PCW = 3'h3;

    localparam logic [31:0] ABS_PSR_RESET = 32'h0000_00d3;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } abs_flags_t;

    typedef struct packed {
        logic [31:0] result;
        logic [3:0] dest;
        logic wr_dest;
        logic wr_pc;
    } abs_wb_t;

endpackage : abs_pkg

// *** rtl/abs_alu_shifter.sv ***
// data processing execution unit: barrel shifter, 16-op alu, flag update and status restore
// assumes decoder presents one instruction with operands read from the register file; holds
// the status words itself, with the saved word loaded by the surrounding core.
// Function
// - logical ops with flag set: v kept, c from shifter, z zero, n bit31
// - opcode decode: and, xor, sub, rsb, add, adc, swc, rswc, or, mov, clear, inverted
// - swc is a-b+c-1; rswc is b-a+c-1
// - codes 1000-1011 do and/xor/sub/add, flags only, no destination write
// - arithmetic ops with flag set: v signed overflow, c carry out, z, n
// - immediate shift amount is 5 bits, selects one of four shift types
// - left shift fills zeros; last bit out becomes shifter carry
// - immediate left shift by zero passes source, carry is old flag
// - immediate right logical zero means shift 32: zero, carry bit31
// - arithmetic right fills bit31; immediate zero means shift 32
// - rotate right reinserts low bits at the top
// - immediate rotate zero is rotate-extend through carry, 33 bits
// - register shift uses low byte; zero passes source and old carry
// - register left by 32 gives zero, carry bit0; beyond gives carry zero
// - register right by 32: carry bit31; beyond zero; arith fills bit31
// - register rotate by 32 returns source, carry bit31; larger wraps mod 32
// - register shift with bit 7 set is not data processing
// - immediate operand is 8 bits rotated right by twice 4-bit field
// - pc destination without flag set: write pc, status untouched
// - pc destination with flag set: write pc, saved status copied to current
// - pc as operand reads address plus 8, or plus 12 for register shift
// - legacy test-restore copies saved status in privileged mode only
// - cycles: 1s, +1i register shift, pc write 2s+1n, +1i
// - first operand is a register; second by immediate bit; flags by s bit
`timescale 1ns/1ps
module abs_alu_shifter
    import abs_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic issue,
    input wire logic [31:0] instr,
    input wire logic [31:0] instr_addr,
    input wire logic legacy_test_restore,
    input wire logic [31:0] first_operand_reg,
    input wire logic [31:0] shift_source_reg,
    input wire logic [31:0] shift_amount_reg,
    input wire logic saved_load,
    input wire logic [31:0] saved_load_value,
    output logic busy,
    output logic not_data_proc,
    output abs_wb_t wb,
    output logic wb_valid,
    output logic [2:0] cycle_count,
    output logic [31:0] current_status_word,
    output logic [31:0] saved_status_word
);

    // decoded fields
    logic ibit;
    logic sbit;
    logic regsh;
    abs_op_t op;
    abs_shift_t stype;
    logic [4:0] shimm;
    logic [3:0] opa_idx;
    logic [3:0] src_idx;
    logic [3:0] rd_idx;
    logic cin;

    assign ibit = instr[ABS_IBIT];
    assign sbit = instr[ABS_SBIT];
    assign regsh = ~ibit & instr[ABS_REGSH_BIT];
    assign op = abs_op_t'(instr[ABS_OP_LSB +: 4]);
    assign stype = abs_shift_t'(instr[ABS_STYPE_LSB +: 2]);
    assign shimm = instr[ABS_SHAMT_LSB +: 5];
    assign opa_idx = instr[ABS_OPA_LSB +: 4];
    assign src_idx = instr[ABS_SRC_LSB +: 4];
    assign rd_idx = instr[ABS_RD_LSB +: 4];
    assign cin = current_status_word[29];

    // pc operand is prefetch-ahead of the instruction address
    function automatic logic [31:0] abs_read_op(input logic [3:0] idx, input logic [31:0] val,
                                                input logic [31:0] addr, input logic rsh);
        logic [31:0] ahead;
        ahead = rsh ? ABS_PC_AHEAD_REG : ABS_PC_AHEAD_IMM;
        if (idx == ABS_PC_INDEX)
            abs_read_op = addr + ahead;
        else
            abs_read_op = val;
    endfunction : abs_read_op

    logic [31:0] opa;
    logic [31:0] src;
    assign opa = abs_read_op(opa_idx, first_operand_reg, instr_addr, regsh);
    assign src = abs_read_op(src_idx, shift_source_reg, instr_addr, regsh);

    assign not_data_proc = regsh & instr[ABS_BIT7];

    // barrel shifter
    logic [31:0] opb;
    logic sh_c;
    always_comb
    begin
        logic [7:0] amt;
        logic [63:0] wide;
        logic [4:0] rot;
        logic [31:0] imm;
        amt = 8'h00;
        wide = 64'h0;
        rot = 5'h00;
        imm = {24'h0, instr[ABS_IMM8_LSB +: 8]};
        opb = src;
        sh_c = cin;
        if (ibit)
        begin
            rot = {instr[ABS_ROT_LSB +: 4], 1'b0};
            opb = (imm >> rot) | (imm << (6'h20 - {1'b0, rot}));
            // carry from rotated immediate only when rotation is non-zero
            sh_c = (rot != 5'h00) ? opb[31] : cin;
        end
        else
        begin
            if (regsh)
                amt = shift_amount_reg[7:0];
            else
                amt = {3'h0, shimm};
            if (!regsh && shimm == 5'h00 && stype != ABS_SH_LL)
                amt = ABS_SH32;
            if (amt == 8'h00 && !(regsh == 1'b0 && stype == ABS_SH_RR))
            begin
                opb = src;
                sh_c = cin;
            end
            else
            begin
                unique case (stype)
                    ABS_SH_LL:
                    begin
                        if (amt > ABS_SH32)
                        begin
                            opb = 32'h0;
                            sh_c = 1'b0;
                        end
                        else
                        begin
                            wide = {32'h0, src} << amt[5:0];
                            opb = wide[31:0];
                            sh_c = wide[32];
                        end
                    end
                    ABS_SH_LR:
                    begin
                        if (amt > ABS_SH32)
                        begin
                            opb = 32'h0;
                            sh_c = 1'b0;
                        end
                        else
                        begin
                            wide = {src, 32'h0} >> amt[5:0];
                            opb = wide[63:32];
                            sh_c = wide[31];
                        end
                    end
                    ABS_SH_AR:
                    begin
                        if (amt >= ABS_SH32)
                        begin
                            opb = {32{src[31]}};
                            sh_c = src[31];
                        end
                        else
                        begin
                            wide = 64'($signed({src, 32'h0}) >>> amt[5:0]);
                            opb = wide[63:32];
                            sh_c = wide[31];
                        end
                    end
                    ABS_SH_RR:
                    begin
                        if (!regsh && shimm == 5'h00)
                        begin
                            opb = {cin, src[31:1]};
                            sh_c = src[0];
                        end
                        else
                        begin
                            // wraps into 1..32: low five bits zero means a full turn
                            rot = amt[4:0];
                            opb = (src >> rot) | (src << (6'h20 - {1'b0, rot}));
                            sh_c = (rot == 5'h00) ? src[31] : src[rot - 5'h01];
                        end
                    end
                endcase
            end
        end
    end

    // alu
    logic [31:0] res;
    logic alu_c;
    logic alu_v;
    logic arith;
    logic writes;
    always_comb
    begin
        logic [32:0] sum;
        logic [31:0] x;
        logic [31:0] y;
        logic ci;
        sum = 33'h0;
        x = opa;
        y = opb;
        ci = 1'b0;
        arith = 1'b1;
        writes = 1'b1;
        res = 32'h0;
        unique case (op)
            ABS_OP_SUB, ABS_OP_TSUB:
            begin
                y = ~opb;
                ci = 1'b1;
            end
            ABS_OP_RSB:
            begin
                x = opb;
                y = ~opa;
                ci = 1'b1;
            end
            ABS_OP_ADD, ABS_OP_TADD: ci = 1'b0;
            ABS_OP_ADC: ci = cin;
            ABS_OP_SWC:
            begin
                y = ~opb;
                ci = cin;
            end
            ABS_OP_RSWC:
            begin
                x = opb;
                y = ~opa;
                ci = cin;
            end
            default: arith = 1'b0;
        endcase
        sum = {1'b0, x} + {1'b0, y} + {32'h0, ci};
        unique case (op)
            ABS_OP_AND, ABS_OP_TAND: res = opa & opb;
            ABS_OP_XOR, ABS_OP_TXOR: res = opa ^ opb;
            ABS_OP_OR: res = opa | opb;
            ABS_OP_MOV: res = opb;
            ABS_OP_CLR: res = opa & ~opb;
            ABS_OP_INV: res = ~opb;
            default: res = sum[31:0];
        endcase
        if (op inside {ABS_OP_TAND, ABS_OP_TXOR, ABS_OP_TSUB, ABS_OP_TADD})
            writes = 1'b0;
        alu_c = sum[32];
        alu_v = (x[31] == y[31]) && (sum[31] != x[31]);
    end

    // status words and write-back
    logic [31:0] cur_reg;
    logic [31:0] cur_next;
    logic [31:0] sav_reg;
    logic [31:0] sav_next;
    abs_wb_t wb_reg;
    abs_wb_t wb_next;
    logic wbv_reg;
    logic wbv_next;
    logic [2:0] cyc_reg;
    logic [2:0] cyc_next;
    logic [2:0] wait_reg;
    logic [2:0] wait_next;

    logic dest_pc;
    logic go;
    abs_flags_t nf;
    assign dest_pc = (rd_idx == ABS_PC_INDEX);
    assign go = issue & ~busy & ~not_data_proc;

    always_comb
    begin
        logic [2:0] cyc;
        cyc = ABS_CYC_PLAIN;
        cur_next = cur_reg;
        sav_next = saved_load ? saved_load_value : sav_reg;
        wb_next = wb_reg;
        wbv_next = 1'b0;
        cyc_next = cyc_reg;
        wait_next = (wait_reg != 3'h0) ? wait_reg - 3'h1 : 3'h0;
        nf = abs_flags_t'(cur_reg[31:28]);
        if (go)
        begin
            if (legacy_test_restore)
            begin
                if (cur_reg[4:0] != ABS_USER_MODE)
                    cur_next = sav_reg;
            end
            else if (sbit && dest_pc && writes)
                cur_next = sav_reg;
            else if (sbit)
            begin
                nf.z = (res == 32'h0);
                nf.n = res[31];
                if (arith)
                begin
                    nf.c = alu_c;
                    nf.v = alu_v;
                end
                else
                    nf.c = sh_c;
                cur_next = {nf, cur_reg[27:0]};
            end
            // without the s bit or legacy test-restore the current word stays as it is
            wb_next.result = res;
            wb_next.dest = rd_idx;
            wb_next.wr_dest = writes & ~legacy_test_restore;
            wb_next.wr_pc = writes & ~legacy_test_restore & dest_pc;
            wbv_next = 1'b1;
            if (wb_next.wr_pc)
                cyc = ABS_CYC_PCW;
            if (regsh)
                cyc = cyc + ABS_CYC_INT;
            cyc_next = cyc;
            wait_next = cyc - 3'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cur_reg <= ABS_PSR_RESET;
            sav_reg <= ABS_PSR_RESET;
            wb_reg <= '0;
            wbv_reg <= 1'b0;
            cyc_reg <= 3'h0;
            wait_reg <= 3'h0;
        end
        else
        begin
            cur_reg <= cur_next;
            sav_reg <= sav_next;
            wb_reg <= wb_next;
            wbv_reg <= wbv_next;
            cyc_reg <= cyc_next;
            wait_reg <= wait_next;
        end
    end

    assign busy = (wait_reg != 3'h0);
    assign wb = wb_reg;
    assign wb_valid = wbv_reg;
    assign cycle_count = cyc_reg;
    assign current_status_word = cur_reg;
    assign saved_status_word = sav_reg;

    a_logic_flags: assert property (@(posedge clock) disable iff (!rstn)
        go && sbit && !arith && !dest_pc && !legacy_test_restore
        |=> cur_reg[28] == $past(cur_reg[28]) && cur_reg[29] == $past(sh_c))
        else $error("logical op flag update wrong");
    a_arith_carry: assert property (@(posedge clock) disable iff (!rstn)
        go && sbit && arith && !dest_pc && !legacy_test_restore
        |=> cur_reg[29] == $past(alu_c) && cur_reg[30] == (wb.result == 32'h0))
        else $error("arithmetic flag update wrong");
    a_test_nowrite: assert property (@(posedge clock) disable iff (!rstn)
        go && op inside {ABS_OP_TAND, ABS_OP_TXOR, ABS_OP_TSUB, ABS_OP_TADD}
        |=> wb_valid && !wb.wr_dest)
        else $error("test op wrote destination");
    a_pc_nos_keep: assert property (@(posedge clock) disable iff (!rstn)
        go && !sbit && !legacy_test_restore && !saved_load |=> $stable(cur_reg))
        else $error("status changed without s bit");
    a_pc_restore: assert property (@(posedge clock) disable iff (!rstn)
        go && sbit && dest_pc && writes && !legacy_test_restore
        |=> cur_reg == $past(sav_reg) && wb.wr_pc)
        else $error("pc write did not restore status");
    a_left_zero: assert property (@(posedge clock) disable iff (!rstn)
        !ibit && !regsh && stype == ABS_SH_LL && shimm == 5'h00 |-> opb == src && sh_c == cin)
        else $error("left shift zero not transparent");
    a_right_32: assert property (@(posedge clock) disable iff (!rstn)
        !ibit && !regsh && stype == ABS_SH_LR && shimm == 5'h00 |-> opb == 32'h0 && sh_c == src[31])
        else $error("right shift 32 encoding wrong");
    a_extend_form: assert property (@(posedge clock) disable iff (!rstn)
        !ibit && !regsh && stype == ABS_SH_RR && shimm == 5'h00 |-> {opb, sh_c} == {cin, src})
        else $error("rotate extend wrong");
    a_bit7_block: assert property (@(posedge clock) disable iff (!rstn)
        issue && not_data_proc && !busy |=> !wb_valid)
        else $error("bit 7 form executed");
    a_busy_len: assert property (@(posedge clock) disable iff (!rstn)
        go && dest_pc && writes && !legacy_test_restore && !regsh |=> busy [*2] ##1 !busy)
        else $error("pc write cycle count wrong");

endmodule : abs_alu_shifter

// *** verif/abs_regfile_model.sv ***
// register file and operand fetch standing in for the decoder side of the core
// assumes instr carries the operand index at 19:16, amount index at 11:8, source at 3:0
`timescale 1ns/1ps
module abs_regfile_model
    import abs_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [31:0] instr,
    input wire abs_wb_t wb,
    input wire logic wb_valid,
    output logic [31:0] first_operand_reg,
    output logic [31:0] shift_source_reg,
    output logic [31:0] shift_amount_reg
);
    logic [31:0] rf_reg [0:15];

    // the first operand always comes from a register
    always_comb
    begin
        first_operand_reg = rf_reg[instr[ABS_OPA_LSB +: 4]];
        shift_source_reg = rf_reg[instr[ABS_SRC_LSB +: 4]];
        shift_amount_reg = rf_reg[instr[ABS_AMT_LSB +: 4]];
    end

    // plain always: the bench also writes entries, so no single-driver block here
    always @(posedge clock)
    begin
        if (rstn && wb_valid && wb.wr_dest)
        begin
            rf_reg[wb.dest] <= wb.result;
        end
    end
endmodule : abs_regfile_model

// *** verif/tb.sv ***
// self-checking bench for the data processing execution unit
// assumes operands come from the register file model; inputs change on the falling edge
`timescale 1ns/1ps
module tb;
    import abs_pkg::*;

    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic issue = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [31:0] instr_addr = 32'h0000_0100;
    logic legacy_test_restore = 1'b0;
    logic saved_load = 1'b0;
    logic [31:0] saved_load_value = 32'h0;
    logic [31:0] first_operand_reg;
    logic [31:0] shift_source_reg;
    logic [31:0] shift_amount_reg;
    logic busy;
    logic not_data_proc;
    abs_wb_t wb;
    logic wb_valid;
    logic [2:0] cycle_count;
    logic [31:0] current_status_word;
    logic [31:0] saved_status_word;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;

    always #4 clock = ~clock;

    abs_alu_shifter DUT (.clock(clock), .rstn(rstn), .issue(issue), .instr(instr), .instr_addr(instr_addr),
        .legacy_test_restore(legacy_test_restore), .first_operand_reg(first_operand_reg),
        .shift_source_reg(shift_source_reg), .shift_amount_reg(shift_amount_reg), .saved_load(saved_load),
        .saved_load_value(saved_load_value), .busy(busy), .not_data_proc(not_data_proc), .wb(wb),
        .wb_valid(wb_valid), .cycle_count(cycle_count), .current_status_word(current_status_word),
        .saved_status_word(saved_status_word));

    abs_regfile_model u_rf (.clock(clock), .rstn(rstn), .instr(instr), .wb(wb), .wb_valid(wb_valid),
        .first_operand_reg(first_operand_reg), .shift_source_reg(shift_source_reg),
        .shift_amount_reg(shift_amount_reg));

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // generous ceiling: the whole sequence needs well under two hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_flags(input logic [3:0] f);
        chk("flags nzcv", {28'h0, f}, {28'h0, current_status_word[31:28]});
    endtask : chk_flags

    function automatic logic [31:0] mk(input logic i, input logic [3:0] op, input logic s, input logic [3:0] a,
        input logic [3:0] rd, input logic [11:0] op2);
        return {4'he, 2'b00, i, op, s, a, rd, op2};
    endfunction : mk

    function automatic logic [11:0] shi(input logic [4:0] amt, input logic [1:0] st, input logic [3:0] sr);
        return {amt, st, 1'b0, sr};
    endfunction : shi

    function automatic logic [11:0] shr(input logic [3:0] ar, input logic [1:0] st, input logic [3:0] sr);
        return {ar, 1'b0, st, 1'b1, sr};
    endfunction : shr

    task automatic set_reg(input int idx, input logic [31:0] v);
        u_rf.rf_reg[idx] = v;
    endtask : set_reg

    // entered and left at a falling edge; checks the one-cycle answer and the busy length
    task automatic do_op(input logic [31:0] ins, input logic [2:0] cyc);
        int n;
        instr = ins;
        issue = 1'b1;
        @(negedge clock);
        issue = 1'b0;
        chk("wb_valid", 32'h1, 32'(wb_valid));
        n = 0;
        while (busy === 1'b1 && n < 8)
        begin
            @(negedge clock);
            n++;
        end
        chk("busy cycles", 32'(cyc) - 32'h1, 32'(n));
        chk("cycle_count", 32'(cyc), 32'(cycle_count));
        // idle edge: issue never falls and rises in one step
        @(negedge clock);
        chk("wb_valid pulse", 32'h0, 32'(wb_valid));
    endtask : do_op

    task automatic load_saved(input logic [31:0] v);
        saved_load = 1'b1;
        saved_load_value = v;
        @(negedge clock);
        saved_load = 1'b0;
        chk("saved word", v, saved_status_word);
    endtask : load_saved

    task automatic t_reset();
        chk("status after reset", ABS_PSR_RESET, current_status_word);
        chk("wb_valid after reset", 32'h0, 32'(wb_valid));
        chk("cycle_count after reset", 32'h0, 32'(cycle_count));
        $display("t_reset done");
    endtask : t_reset

    // carry stays clear through codes 0-7, which run without flag update
    task automatic t_opcodes();
        logic [31:0] exp_tab [0:15] = '{32'h0, 32'hff, 32'he1, 32'hffffff1f, 32'hff, 32'hff, 32'he0,
            32'hffffff1e, 32'h0, 32'hff, 32'he1, 32'hff, 32'hff, 32'h0f, 32'hf0, 32'hfffffff0};
        logic [3:0] op;
        set_reg(1, 32'hf0);
        for (int k = 0; k < 16; k++)
        begin
            op = 4'(k);
            do_op(mk(1'b1, op, op[3:2] == 2'b10, 4'h1, 4'h2, 12'h00f), 3'h1);
            chk("wr_dest", {31'h0, op[3:2] != 2'b10}, 32'(wb.wr_dest));
            if (op[3:2] != 2'b10)
                chk("result", exp_tab[k], wb.result);
        end
        $display("t_opcodes done");
    endtask : t_opcodes

    task automatic t_arith();
        set_reg(1, 32'h7fffffff);
        do_op(mk(1'b1, ABS_OP_ADD, 1'b1, 4'h1, 4'h2, 12'h001), 3'h1);
        chk("add overflow", 32'h80000000, wb.result);
        chk_flags(4'b1001);
        set_reg(1, 32'h5);
        do_op(mk(1'b1, ABS_OP_SUB, 1'b1, 4'h1, 4'h2, 12'h005), 3'h1);
        chk_flags(4'b0110);
        set_reg(1, 32'h7);
        do_op(mk(1'b1, ABS_OP_SWC, 1'b0, 4'h1, 4'h2, 12'h002), 3'h1);
        chk("swc with carry", 32'h5, wb.result);
        do_op(mk(1'b1, ABS_OP_RSWC, 1'b0, 4'h1, 4'h2, 12'h002), 3'h1);
        chk("rswc with carry", 32'hfffffffb, wb.result);
        do_op(mk(1'b1, ABS_OP_ADC, 1'b0, 4'h1, 4'h2, 12'h002), 3'h1);
        chk("adc with carry", 32'ha, wb.result);
        set_reg(1, 32'h7fffffff);
        do_op(mk(1'b1, ABS_OP_ADD, 1'b1, 4'h1, 4'h2, 12'h001), 3'h1);
        set_reg(4, 32'h80000000);
        do_op(mk(1'b0, ABS_OP_MOV, 1'b1, 4'h0, 4'h2, shi(5'h1, ABS_SH_LL, 4'h4)), 3'h1);
        chk("left shift out", 32'h0, wb.result);
        chk_flags(4'b0111);
        $display("t_arith done");
    endtask : t_arith

    // entries 2 and 3 depend on the carry that the entry before them leaves
    task automatic t_shift_imm();
        logic [1:0] st_tab [0:7] = '{ABS_SH_AR, ABS_SH_LR, ABS_SH_RR, ABS_SH_LL, ABS_SH_RR, ABS_SH_LR,
            ABS_SH_AR, ABS_SH_LL};
        logic [4:0] amt_tab [0:7] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h4, 5'h4, 5'h4, 5'h4};
        logic [31:0] res_tab [0:7] = '{32'hffffffff, 32'h0, 32'hc0000000, 32'h80000001, 32'h18000000,
            32'h08000000, 32'hf8000000, 32'h10};
        logic c_tab [0:7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        set_reg(4, 32'h80000001);
        for (int k = 0; k < 8; k++)
        begin
            do_op(mk(1'b0, ABS_OP_MOV, 1'b1, 4'h0, 4'h2, shi(amt_tab[k], st_tab[k], 4'h4)), 3'h1);
            chk("imm shift result", res_tab[k], wb.result);
            chk("imm shift carry", {31'h0, c_tab[k]}, 32'(current_status_word[29]));
        end
        $display("t_shift_imm done");
    endtask : t_shift_imm

    task automatic t_shift_reg();
        logic [1:0] st_tab [0:8] = '{ABS_SH_AR, ABS_SH_LL, ABS_SH_LL, ABS_SH_LR, ABS_SH_LL, ABS_SH_LR,
            ABS_SH_RR, ABS_SH_RR, ABS_SH_LL};
        logic [31:0] amt_tab [0:8] = '{32'hc8, 32'h20, 32'h21, 32'h20, 32'h0, 32'h28, 32'h20, 32'h24, 32'h104};
        logic [31:0] res_tab [0:8] = '{32'hffffffff, 32'h0, 32'h0, 32'h0, 32'h80000001, 32'h0, 32'h80000001,
            32'h18000000, 32'h10};
        logic c_tab [0:8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        set_reg(4, 32'h80000001);
        for (int k = 0; k < 9; k++)
        begin
            set_reg(3, amt_tab[k]);
            do_op(mk(1'b0, ABS_OP_MOV, 1'b1, 4'h0, 4'h2, shr(4'h3, st_tab[k], 4'h4)), 3'h2);
            chk("reg shift result", res_tab[k], wb.result);
            chk("reg shift carry", {31'h0, c_tab[k]}, 32'(current_status_word[29]));
        end
        instr = mk(1'b0, ABS_OP_MOV, 1'b1, 4'h0, 4'h2, shr(4'h3, ABS_SH_LL, 4'h4) | 12'h080);
        issue = 1'b1;
        #1;
        chk("not_data_proc", 32'h1, 32'(not_data_proc));
        @(negedge clock);
        issue = 1'b0;
        chk("refused wb_valid", 32'h0, 32'(wb_valid));
        @(negedge clock);
        $display("t_shift_reg done");
    endtask : t_shift_reg

    task automatic t_pc();
        logic [31:0] st;
        set_reg(0, 32'h0);
        set_reg(3, 32'h0);
        do_op(mk(1'b1, ABS_OP_ADD, 1'b0, 4'hf, 4'h2, 12'h000), 3'h1);
        chk("pc plus 8", 32'h108, wb.result);
        chk("wr_pc clear", 32'h0, 32'(wb.wr_pc));
        do_op(mk(1'b0, ABS_OP_ADD, 1'b0, 4'hf, 4'h2, shr(4'h3, ABS_SH_LL, 4'h0)), 3'h2);
        chk("pc plus 12", 32'h10c, wb.result);
        do_op(mk(1'b1, ABS_OP_MOV, 1'b0, 4'h0, 4'h2, 12'h4ff), 3'h1);
        chk("imm rotate", 32'hff000000, wb.result);
        st = current_status_word;
        do_op(mk(1'b1, ABS_OP_MOV, 1'b0, 4'h0, 4'hf, 12'h040), 3'h3);
        chk("pc write", 32'h40, wb.result);
        chk("wr_pc", 32'h1, 32'(wb.wr_pc));
        chk("status kept", st, current_status_word);
        chk("pc dest", 32'hf, 32'(wb.dest));
        do_op(mk(1'b0, ABS_OP_MOV, 1'b0, 4'h0, 4'hf, shr(4'h3, ABS_SH_LL, 4'h0)), 3'h4);
        chk("pc write reg shift", 32'h0, wb.result);
        chk("status kept reg shift", st, current_status_word);
        load_saved(32'h4000001f);
        legacy_test_restore = 1'b1;
        do_op(mk(1'b1, ABS_OP_TXOR, 1'b1, 4'h1, 4'h0, 12'h000), 3'h1);
        legacy_test_restore = 1'b0;
        chk("legacy privileged", 32'h4000001f, current_status_word);
        load_saved(32'ha0000010);
        do_op(mk(1'b1, ABS_OP_MOV, 1'b1, 4'h0, 4'hf, 12'h080), 3'h3);
        chk("restore on pc write", 32'ha0000010, current_status_word);
        load_saved(32'h000000d3);
        legacy_test_restore = 1'b1;
        do_op(mk(1'b1, ABS_OP_TXOR, 1'b1, 4'h1, 4'h0, 12'h000), 3'h1);
        legacy_test_restore = 1'b0;
        chk("legacy user", 32'ha0000010, current_status_word);
        $display("t_pc done");
    endtask : t_pc

    initial
    begin
        repeat (20) @(negedge clock);
        rstn = 1'b1;
        t_reset();
        t_opcodes();
        t_arith();
        t_shift_imm();
        t_shift_reg();
        t_pc();
        give_verdict();
    end
endmodule : tb
